// >>> include/hpp_pkg.sv
// shared constants and types of the handshaked parallel port
package hpp_pkg;

  // port geometry
  localparam int unsigned NUM_PORTS  = 4;          // 8-bit ports on the connector
  localparam int unsigned PORT_BITS  = 8;          // lines per port
  localparam int unsigned DATA_BITS  = 32;         // widest logical port
  localparam int unsigned NUM_SETS   = 2;          // handshake line sets
  localparam int unsigned STB_PORTS  = 3;          // ports present in strobe style

  // clock rate
  localparam int unsigned CLK_PERIOD_PS = 8000;    // 125 MHz system clock

  // acknowledge pulse back to the instrument, least width
  localparam int unsigned ACK_PULSE_NS  = 40;
  localparam int unsigned ACK_PULSE_CYC =
    (ACK_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // half period of the burst peripheral clock, least
  localparam int unsigned PCLK_HALF_NS  = 16;
  localparam int unsigned PCLK_HALF_CYC =
    (PCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // counter width for both timers
  localparam int unsigned CNT_BITS = 8;

  // idle levels after reset
  localparam logic [1:0] RST_ACK      = 2'h0;      // acknowledge inactive
  localparam logic [1:0] RST_PCLK     = 2'h0;      // peripheral clock parked low
  localparam logic [1:0] RST_IN_FULL  = 2'h0;      // input-full low
  localparam logic [1:0] RST_OUT_FULL = 2'h3;      // output-full (active low) high
  localparam logic [1:0] RST_SYNC_HI  = 2'h3;      // active-low pins idle high

  // handshake styles
  typedef enum logic {
    HPP_STYLE_REQACK,
    HPP_STYLE_STROBE
  } hpp_style_t;

  // transfer sequencer states
  typedef enum logic [2:0] {
    HPP_IDLE,
    HPP_IN_WAIT,
    HPP_IN_PUSH,
    HPP_IN_ACK,
    HPP_BURST,
    HPP_OUT_LOAD,
    HPP_OUT_SHOW,
    HPP_OUT_DONE
  } hpp_state_t;

endpackage

// >>> include/hpp_stream_if.sv
`timescale 1ns/1ps
// one word stream with valid and ready
interface hpp_stream_if #(
  parameter int unsigned DW = 32
);
  logic          valid;  // word offered
  logic          ready;  // word can be taken
  logic [DW-1:0] data;   // the word

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> rtl/hpp_skid_buf.sv
`timescale 1ns/1ps
// two-entry buffer, both handshakes registered
module hpp_skid_buf #(
  parameter int unsigned DW = 32
) (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   ce_i,
  // filling side
  hpp_stream_if.snk   up,
  // draining side
  hpp_stream_if.src   dn
);

  // whole state of the buffer
  typedef struct packed {
    logic [DW-1:0] head;    // oldest word
    logic [DW-1:0] tail;    // second word
    logic [1:0]    fill;    // words held
    logic          in_rdy;  // room for a word
    logic          out_vld; // a word is held
  } hpp_buf_st_t;

  hpp_buf_st_t st_reg;      // registered state
  hpp_buf_st_t st_next;     // next state

  // offered handshakes straight from flops
  assign up.ready = st_reg.in_rdy;
  assign dn.valid = st_reg.out_vld;
  assign dn.data  = st_reg.head;

  // fill and drain, a pop and a push may share a cycle
  always_comb begin
    logic       push;
    logic       pop;
    logic [1:0] left;
    push    = up.valid & st_reg.in_rdy;
    pop     = st_reg.out_vld & dn.ready;
    st_next = st_reg;
    left    = st_reg.fill;
    if (pop) begin
      st_next.head = st_reg.tail;
      left         = st_reg.fill - 2'h1;
    end
    if (push) begin
      if (left == 2'h0) begin
        st_next.head = up.data;
      end else begin
        st_next.tail = up.data;
      end
      left = left + 2'h1;
    end
    st_next.fill    = left;
    st_next.in_rdy  = (left != 2'h2);
    st_next.out_vld = (left != 2'h0);
  end

  // state register, frozen while ce_i is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{head: '0, tail: '0, fill: 2'h0, in_rdy: 1'b1, out_vld: 1'b0};
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

endmodule // hpp_skid_buf

// >>> rtl/hpp_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: instrument pulses ready when pattern waits
// RULE2: ready pulse captures one 8-32 bit pattern
// RULE3: pulse back after pattern taken
// RULE4: one read per ready pulse, repeating
// RULE5: request input shows instrument ready
// RULE6: acknowledge output shows device ready
// RULE7: burst mode adds peripheral clock line
// RULE8: strobe/input-full in, output-full/acknowledge out
// RULE9: strobe low latches port inputs
// RULE10: input-full rises once data latched
// RULE11: output-full low while data presented
// RULE12: instrument answers low acknowledge pulse
// RULE13: group with port 0/1 uses set one
// RULE14: ports 2/3 only use set two
// RULE15: set chosen by ports, not group number
// RULE16: strobe style uses last-listed port lines
// RULE17: shared strobe, only last input-full used
// RULE18: output uses last-listed port handshake only
// RULE19: logical port 8, 16, 24, 32 bits
// RULE20: strobe style: three ports, third handshake; code masks data to ports 0 and 1 only
// RULE21: exactly one word per handshake pulse
// RULE22: idle handshake levels until configured
module hpp_port (
  // clock, reset, freeze
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         ce_i,
  // configuration, hold stable while enabled
  input  wire logic                         cfg_enable_i,
  input  wire hpp_pkg::hpp_style_t          cfg_style_i,
  input  wire logic                         cfg_dir_out_i,
  input  wire logic                         cfg_burst_i,
  input  wire logic [3:0]                   cfg_ports_i,
  input  wire logic                         cfg_last_port_i,
  input  wire logic [1:0]                   cfg_width_i,
  // captured words toward the host
  output logic [hpp_pkg::DATA_BITS-1:0]     rx_data_o,
  output logic                              rx_valid_o,
  input  wire logic                         rx_ready_i,
  // words from the host to send
  input  wire logic [hpp_pkg::DATA_BITS-1:0] tx_data_i,
  input  wire logic                         tx_valid_i,
  output logic                              tx_ready_o,
  // port data pins
  input  wire logic [hpp_pkg::DATA_BITS-1:0] port_data_i,
  output logic [hpp_pkg::DATA_BITS-1:0]     port_data_o,
  output logic [hpp_pkg::NUM_PORTS-1:0]     port_data_oe_o,
  // request/acknowledge style pins, one per line set
  input  wire logic [1:0]                   req_i,
  output logic [1:0]                        ack_o,
  output logic [1:0]                        pclk_o,
  // strobe style pins, one per handshaking port
  input  wire logic [1:0]                   input_latch_strobe_n_i,
  output logic [1:0]                        input_full_flag_o,
  output logic [1:0]                        output_full_flag_n_o,
  input  wire logic [1:0]                   out_ack_n_i
);

  localparam int unsigned DW = hpp_pkg::DATA_BITS;                  // word width
  localparam int unsigned CW = hpp_pkg::CNT_BITS;                   // timer width
  localparam logic [CW-1:0] ACK_LAST  = CW'(hpp_pkg::ACK_PULSE_CYC - 1);
  localparam logic [CW-1:0] PCLK_LAST = CW'(hpp_pkg::PCLK_HALF_CYC - 1);

  // whole state of the port
  typedef struct packed {
    logic [1:0]          req_s1;    // request synchroniser, first stage
    logic [1:0]          req_s2;    // request synchroniser, second stage
    logic [1:0]          req_d;     // request, previous sample
    logic [1:0]          stb_s1;    // strobe synchroniser, first stage
    logic [1:0]          stb_s2;    // strobe synchroniser, second stage
    logic [1:0]          stb_d;     // strobe, previous sample
    logic [1:0]          oak_s1;    // output acknowledge, first stage
    logic [1:0]          oak_s2;    // output acknowledge, second stage
    logic [1:0]          oak_d;     // output acknowledge, previous sample
    logic [DW-1:0]       din_s1;    // data pins, first stage
    logic [DW-1:0]       din_s2;    // data pins, second stage
    hpp_pkg::hpp_state_t state;     // sequencer
    logic [DW-1:0]       word;      // latched pattern
    logic [DW-1:0]       dout;      // driven pattern
    logic [3:0]          doe;       // per-port drive enables
    logic [1:0]          ack;       // acknowledge lines
    logic [1:0]          pclk;      // peripheral clock lines
    logic [1:0]          input_full_flag;       // input-full lines
    logic [1:0]          obf_n;     // output-full lines, active low
    logic [CW-1:0]       cnt;       // pulse and clock timer
    logic                push;      // word offered to receive buffer
    logic                pop_rdy;   // ready to take a word to send
  } hpp_st_t;

  hpp_st_t st_reg;                  // registered state
  hpp_st_t st_next;                 // next state

  // buffers on both data paths
  hpp_stream_if #(.DW(DW)) cap_if ();   // sequencer to receive buffer
  hpp_stream_if #(.DW(DW)) rx_if  ();   // receive buffer to host
  hpp_stream_if #(.DW(DW)) tx_if  ();   // host to send buffer
  hpp_stream_if #(.DW(DW)) snd_if ();   // send buffer to sequencer

  // derived selections
  logic          sel;                   // active handshake line set
  logic [3:0]    byte_en;               // lanes that carry data
  logic [DW-1:0] lane_mask;             // byte_en spread to bits
  logic [1:0]    req_rise;              // request rising edges
  logic [1:0]    stb_low;               // strobe held low
  logic [1:0]    stb_rise;              // strobe released
  logic [1:0]    oak_fall;              // output acknowledge falling edges
  logic          strobe_style;          // strobe style selected

  assign strobe_style = (cfg_style_i == hpp_pkg::HPP_STYLE_STROBE);

  // line set choice depends on the ports, or on cfg_last_port_i in strobe style
  always_comb begin
    if (strobe_style) begin
      sel = cfg_last_port_i;                               // RULE16 RULE18
    end else if (cfg_ports_i[1:0] != 2'h0) begin
      sel = 1'b0;                                          // RULE13 RULE15
    end else begin
      sel = 1'b1;                                          // RULE14
    end
  end

  // logical port width and group lanes
  always_comb begin
    logic [3:0] width_en;
    width_en = 4'hF;
    case (cfg_width_i)
      2'h0:    width_en = 4'h1;                            // RULE19
      2'h1:    width_en = 4'h3;
      2'h2:    width_en = 4'h7;
      default: width_en = 4'hF;
    endcase
    byte_en = width_en & cfg_ports_i;
    if (strobe_style) begin
      byte_en = byte_en & 4'h3;                            // RULE20
    end
  end

  // byte enables to bit mask, one lane per port
  genvar g;
  generate
    for (g = 0; g < hpp_pkg::NUM_PORTS; g++) begin : g_lane
      assign lane_mask[g*hpp_pkg::PORT_BITS +: hpp_pkg::PORT_BITS] =
        {hpp_pkg::PORT_BITS{byte_en[g]}};
    end
  endgenerate

  // edges seen only on second synchroniser stage and later
  assign req_rise = st_reg.req_s2 & ~st_reg.req_d;         // RULE5
  assign stb_low  = ~st_reg.stb_s2;
  assign stb_rise = st_reg.stb_s2 & ~st_reg.stb_d;
  assign oak_fall = ~st_reg.oak_s2 & st_reg.oak_d;         // RULE12

  // buffer hookup
  assign cap_if.valid = st_reg.push;
  assign cap_if.data  = st_reg.word;
  assign snd_if.ready = st_reg.pop_rdy;
  assign rx_if.ready  = rx_ready_i;
  assign tx_if.valid  = tx_valid_i;
  assign tx_if.data   = tx_data_i;

  // receive path buffer
  hpp_skid_buf #(.DW(DW)) u_rx_buf (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .up      (cap_if.snk),
    .dn      (rx_if.src)
  );

  // send path buffer
  hpp_skid_buf #(.DW(DW)) u_tx_buf (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .up      (tx_if.snk),
    .dn      (snd_if.src)
  );

  // sequencer and pin synchronisers
  always_comb begin
    st_next = st_reg;
    // two-stage synchronisers, then one history stage
    st_next.req_s1 = req_i;
    st_next.req_s2 = st_reg.req_s1;
    st_next.req_d  = st_reg.req_s2;
    st_next.stb_s1 = input_latch_strobe_n_i;
    st_next.stb_s2 = st_reg.stb_s1;
    st_next.stb_d  = st_reg.stb_s2;
    st_next.oak_s1 = out_ack_n_i;
    st_next.oak_s2 = st_reg.oak_s1;
    st_next.oak_d  = st_reg.oak_s2;
    st_next.din_s1 = port_data_i;
    st_next.din_s2 = st_reg.din_s1;

    case (st_reg.state)
      // parked, all handshake lines idle
      hpp_pkg::HPP_IDLE: begin
        st_next.ack     = hpp_pkg::RST_ACK;                // RULE22
        st_next.pclk    = hpp_pkg::RST_PCLK;
        st_next.input_full_flag     = hpp_pkg::RST_IN_FULL;
        st_next.obf_n   = hpp_pkg::RST_OUT_FULL;
        st_next.doe     = 4'h0;
        st_next.cnt     = '0;
        if (cfg_enable_i) begin
          if (cfg_dir_out_i) begin
            st_next.state   = hpp_pkg::HPP_OUT_LOAD;
            st_next.pop_rdy = 1'b1;
          end else if (!strobe_style && cfg_burst_i) begin
            st_next.state = hpp_pkg::HPP_BURST;            // RULE7
          end else begin
            st_next.state = hpp_pkg::HPP_IN_WAIT;
          end
        end
      end

      // waiting for the instrument's ready pulse
      hpp_pkg::HPP_IN_WAIT: begin
        if (!cfg_enable_i) begin
          st_next.state = hpp_pkg::HPP_IDLE;
        end else if (strobe_style) begin
          if (stb_low[sel]) begin
            st_next.word     = st_reg.din_s2 & lane_mask;  // RULE9 RULE8
            st_next.input_full_flag[sel] = 1'b1;                       // RULE10 RULE17
          end else if (stb_rise[sel] && st_reg.input_full_flag[sel]) begin
            st_next.push  = 1'b1;                          // RULE21
            st_next.state = hpp_pkg::HPP_IN_PUSH;
          end
        end else if (req_rise[sel]) begin
          st_next.word  = st_reg.din_s2 & lane_mask;       // RULE2 RULE1
          st_next.push  = 1'b1;                            // RULE21
          st_next.state = hpp_pkg::HPP_IN_PUSH;
        end
      end

      // word offered to the receive buffer, stalls while full
      hpp_pkg::HPP_IN_PUSH: begin
        if (st_reg.push && cap_if.ready) begin
          st_next.push = 1'b0;
          if (strobe_style) begin
            st_next.input_full_flag[sel] = 1'b0;                       // input-full cleared
            st_next.state    = hpp_pkg::HPP_IN_WAIT;       // RULE4
          end else begin
            st_next.ack[sel] = 1'b1;                       // RULE3 RULE6
            st_next.cnt      = ACK_LAST;
            st_next.state    = hpp_pkg::HPP_IN_ACK;
          end
        end
      end

      // acknowledge pulse of fixed width
      hpp_pkg::HPP_IN_ACK: begin
        if (st_reg.cnt != '0) begin
          st_next.cnt = st_reg.cnt - CW'(1);
        end else begin
          st_next.ack[sel] = 1'b0;                         // RULE3
          st_next.state    = hpp_pkg::HPP_IN_WAIT;         // RULE4
        end
      end

      // burst: one word per peripheral clock rise
      hpp_pkg::HPP_BURST: begin
        if (st_reg.push && cap_if.ready) begin
          st_next.push = 1'b0;
        end
        // ready while room and nothing pending
        st_next.ack[sel] = cfg_enable_i & cap_if.ready & ~st_next.push;  // RULE6
        if (!cfg_enable_i) begin
          st_next.pclk  = hpp_pkg::RST_PCLK;
          st_next.ack   = hpp_pkg::RST_ACK;
          st_next.state = hpp_pkg::HPP_IDLE;
        end else if (st_reg.cnt != '0) begin
          st_next.cnt = st_reg.cnt - CW'(1);
        end else begin
          st_next.cnt       = PCLK_LAST;
          st_next.pclk[sel] = ~st_reg.pclk[sel];           // RULE7
          if (!st_reg.pclk[sel] && st_reg.req_s2[sel] && st_reg.ack[sel]) begin
            st_next.word = st_reg.din_s2 & lane_mask;      // RULE2 RULE21
            st_next.push = 1'b1;
          end
        end
      end

      // fetch the next word to send
      hpp_pkg::HPP_OUT_LOAD: begin
        if (!cfg_enable_i) begin
          st_next.pop_rdy = 1'b0;
          st_next.state   = hpp_pkg::HPP_IDLE;
        end else if (st_reg.pop_rdy && snd_if.valid) begin
          st_next.pop_rdy = 1'b0;
          st_next.dout    = snd_if.data & lane_mask;       // RULE19
          st_next.doe     = byte_en;
          st_next.state   = hpp_pkg::HPP_OUT_SHOW;
          if (strobe_style) begin
            st_next.obf_n[sel] = 1'b0;                     // RULE11 RULE8 RULE18
          end else begin
            st_next.ack[sel] = 1'b1;                       // RULE6
          end
        end
      end

      // data presented until the instrument answers
      hpp_pkg::HPP_OUT_SHOW: begin
        if (strobe_style && oak_fall[sel]) begin
          st_next.obf_n[sel] = 1'b1;                       // RULE12 RULE21
          st_next.state      = hpp_pkg::HPP_OUT_DONE;
        end else if (!strobe_style && req_rise[sel]) begin
          st_next.ack[sel] = 1'b0;                         // RULE5 RULE21
          st_next.state    = hpp_pkg::HPP_OUT_DONE;
        end else if (!cfg_enable_i) begin
          st_next.state = hpp_pkg::HPP_IDLE;
        end
      end

      // word sent, go for the next one
      hpp_pkg::HPP_OUT_DONE: begin
        if (cfg_enable_i) begin
          st_next.pop_rdy = 1'b1;                          // RULE4
          st_next.state   = hpp_pkg::HPP_OUT_LOAD;
        end else begin
          st_next.state = hpp_pkg::HPP_IDLE;
        end
      end

      default: begin
        st_next.state = hpp_pkg::HPP_IDLE;
      end
    endcase
  end

  // state register, frozen while ce_i is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{
        req_s1:  2'h0,
        req_s2:  2'h0,
        req_d:   2'h0,
        stb_s1:  hpp_pkg::RST_SYNC_HI,
        stb_s2:  hpp_pkg::RST_SYNC_HI,
        stb_d:   hpp_pkg::RST_SYNC_HI,
        oak_s1:  hpp_pkg::RST_SYNC_HI,
        oak_s2:  hpp_pkg::RST_SYNC_HI,
        oak_d:   hpp_pkg::RST_SYNC_HI,
        din_s1:  '0,
        din_s2:  '0,
        state:   hpp_pkg::HPP_IDLE,
        word:    '0,
        dout:    '0,
        doe:     4'h0,
        ack:     hpp_pkg::RST_ACK,                         // RULE22
        pclk:    hpp_pkg::RST_PCLK,
        input_full_flag:     hpp_pkg::RST_IN_FULL,
        obf_n:   hpp_pkg::RST_OUT_FULL,
        cnt:     '0,
        push:    1'b0,
        pop_rdy: 1'b0
      };
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign port_data_o          = st_reg.dout;
  assign port_data_oe_o       = st_reg.doe;
  assign ack_o                = st_reg.ack;
  assign pclk_o               = st_reg.pclk;
  assign input_full_flag_o    = st_reg.input_full_flag;
  assign output_full_flag_n_o = st_reg.obf_n;
  assign rx_data_o            = rx_if.data;
  assign rx_valid_o           = rx_if.valid;
  assign tx_ready_o           = tx_if.ready;

endmodule // hpp_port

// >>> testbench/hpp_port_checker.sv
`timescale 1ns/1ps
// pin timing checks
module hpp_port_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // configuration
  input wire logic        cfg_enable_i,
  input wire logic        cfg_style_i,
  input wire logic        cfg_dir_out_i,
  input wire logic [3:0]  cfg_ports_i,
  input wire logic        cfg_last_port_i,
  input wire logic [1:0]  cfg_width_i,
  // streams and pins
  input wire logic [31:0] rx_data_o,
  input wire logic        rx_valid_o,
  input wire logic        tx_ready_o,
  input wire logic [3:0]  port_data_oe_o,
  input wire logic [1:0]  req_i,
  input wire logic [1:0]  ack_o,
  input wire logic [1:0]  input_latch_strobe_n_i,
  input wire logic [1:0]  input_full_flag_o,
  input wire logic [1:0]  output_full_flag_n_o,
  input wire logic [1:0]  out_ack_n_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // mode decodes and active lanes
  logic        rq_in;
  logic        stb;
  logic [3:0]  ln;
  logic [31:0] bm;
  assign rq_in = cfg_enable_i && !cfg_style_i && !cfg_dir_out_i;
  assign stb   = cfg_enable_i && cfg_style_i;
  assign ln    = (4'hF >> (2'h3 - cfg_width_i)) & cfg_ports_i & (stb ? 4'h3 : 4'hF);
  assign bm    = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};

  a_reset_idle_lvl: assert property ($rose(rst_n_i) |-> ack_o == 2'h0 && input_full_flag_o == 2'h0
    && output_full_flag_n_o == 2'h3 && port_data_oe_o == 4'h0 && tx_ready_o && !rx_valid_o)
    else $error("outputs not idle after reset");
  a_ack_after_req: assert property (rq_in && cfg_ports_i[1:0] != 2'h0 && $rose(req_i[0]) |-> ##[3:40] ack_o[0])
    else $error("no ack after request");
  a_ack_five_wide: assert property (rq_in && $rose(ack_o[0]) |-> ack_o[0] [*5] ##1 !ack_o[0])
    else $error("ack width wrong");
  a_lanes_zero: assert property (rx_valid_o |-> (rx_data_o & ~bm) == 32'h0)
    else $error("unused lanes not zero");
  a_set_one_only: assert property (cfg_enable_i && !stb && cfg_ports_i[1:0] != 2'h0 |-> !ack_o[1])
    else $error("second line set active");
  a_set_two_only: assert property (cfg_enable_i && !stb && cfg_ports_i[1:0] == 2'h0 |-> !ack_o[0])
    else $error("first line set active");
  a_strobe_latch: assert property (stb && !cfg_dir_out_i && $fell(input_latch_strobe_n_i[cfg_last_port_i])
    |-> ##[2:4] input_full_flag_o[cfg_last_port_i]) else $error("input full not raised");
  a_last_port_lines: assert property (stb |-> !input_full_flag_o[~cfg_last_port_i]
    && output_full_flag_n_o[~cfg_last_port_i]) else $error("unused port flags moved");
  a_full_shows_data: assert property (stb && $fell(output_full_flag_n_o[cfg_last_port_i]) |-> port_data_oe_o == ln)
    else $error("data not driven");
  a_full_released: assert property (stb && !output_full_flag_n_o[cfg_last_port_i]
    && $fell(out_ack_n_i[cfg_last_port_i]) |-> ##[2:4] output_full_flag_n_o[cfg_last_port_i])
    else $error("output full not released");
endmodule // hpp_port_checker

// >>> testbench/hpp_instr_model.sv
`timescale 1ns/1ps
// instrument at the far side
module hpp_instr_model (
  // clock
  input  wire logic        clk_i,
  // pins toward the device
  output logic [31:0]      drv_data_o,
  input  wire logic [31:0] dev_data_i,
  output logic [1:0]       req_o,
  input  wire logic [1:0]  ack_i,
  output logic [1:0]       strobe_n_o,
  input  wire logic [1:0]  in_full_i,
  input  wire logic [1:0]  out_full_n_i,
  output logic [1:0]       out_ack_n_o,
  // word taken by the instrument
  output logic             got_o,
  output logic [31:0]      got_data_o
);
  // idle pin levels
  initial begin
    drv_data_o = 32'h0;
    req_o = 2'h0;
    strobe_n_o = 2'h3;
    out_ack_n_o = 2'h3;
    got_o = 1'b0;
    got_data_o = 32'h0;
  end
  // wait edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // request style word
  task automatic req_word(input int s, input logic [31:0] w);
    drv_data_o = w;
    tick(2);
    req_o[s] = 1'b1;
    @(posedge clk_i iff ack_i[s]);
    @(posedge clk_i iff !ack_i[s]);
    #1 req_o[s] = 1'b0;
    drv_data_o = ~w;
    tick(3);
  endtask
  // strobe style word on the shared strobe
  task automatic strobe_word(input int s, input logic [31:0] w);
    drv_data_o = w;
    tick(2);
    strobe_n_o[s] = 1'b0;
    @(posedge clk_i iff in_full_i[s]);
    tick(1);
    strobe_n_o[s] = 1'b1;
    @(posedge clk_i iff !in_full_i[s]);
    #1 drv_data_o = ~w;
    tick(3);
  endtask
  // take a shown word, random stall
  task automatic take_word(input logic st, input int s);
    if (st) @(posedge clk_i iff !out_full_n_i[s]);
    else @(posedge clk_i iff ack_i[s]);
    #1 got_data_o = dev_data_i;
    got_o = 1'b1;
    tick(1);
    got_o = 1'b0;
    tick(int'($urandom_range(3, 0)));
    if (st) begin
      out_ack_n_o[s] = 1'b0;
      tick(2);
      out_ack_n_o[s] = 1'b1;
      @(posedge clk_i iff out_full_n_i[s]);
    end else begin
      req_o[s] = 1'b1;
      @(posedge clk_i iff !ack_i[s]);
      #1 req_o[s] = 1'b0;
    end
    tick(3);
  endtask
endmodule // hpp_instr_model

// >>> testbench/handshaked_parallel_port_test.sv
`timescale 1ns/1ps
// mode table, every word checked
module handshaked_parallel_port_test;
  logic                clk_i, rst_n_i, rx_ready_i, tx_valid_i, rx_valid_o, tx_ready_o, got;
  logic                cfg_enable_i, cfg_dir_out_i, cfg_last_port_i;
  hpp_pkg::hpp_style_t cfg_style_i;
  logic [3:0]          cfg_ports_i, port_data_oe_o;
  logic [1:0]          cfg_width_i, req_i, ack_o, pclk_o, stb_n, in_full, out_full_n, out_ack_n;
  logic [31:0]         rx_data_o, tx_data_i, port_data_i, port_data_o, got_data, m;
  logic [31:0]         exp_q [$];
  int                  errors, n_checks;
  // {strobe, out, ports, last, width}, sets chosen by ports, or by last in strobe style
  localparam logic [8:0] CASES [10] = '{9'h07B, 9'h078, 9'h011, 9'h07A, 9'h063, 9'h119, 9'h11C, 9'h19D,
    9'h0E3, 9'h09A};

  hpp_port u_hpp_port (.clk_i, .rst_n_i, .ce_i(1'b1), .cfg_enable_i, .cfg_style_i, .cfg_dir_out_i,
    .cfg_burst_i(1'b0), .cfg_ports_i, .cfg_last_port_i, .cfg_width_i, .rx_data_o, .rx_valid_o, .rx_ready_i,
    .tx_data_i, .tx_valid_i, .tx_ready_o, .port_data_i, .port_data_o, .port_data_oe_o, .req_i, .ack_o,
    .pclk_o, .input_latch_strobe_n_i(stb_n), .input_full_flag_o(in_full), .output_full_flag_n_o(out_full_n),
    .out_ack_n_i(out_ack_n));
  hpp_instr_model u_hpp_instr_model (.clk_i, .drv_data_o(port_data_i), .dev_data_i(port_data_o),
    .req_o(req_i), .ack_i(ack_o), .strobe_n_o(stb_n), .in_full_i(in_full), .out_full_n_i(out_full_n),
    .out_ack_n_o(out_ack_n), .got_o(got), .got_data_o(got_data));

  initial begin clk_i = 1'b0; forever #4 clk_i = ~clk_i; end

  // active lanes
  function automatic logic [31:0] lane_bytes();
    logic [3:0] l;
    l = (4'hF >> (2'h3 - cfg_width_i)) & cfg_ports_i & (cfg_style_i == hpp_pkg::HPP_STYLE_STROBE ? 4'h3 : 4'hF);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  task automatic chk_rx(input logic [31:0] v);
    logic [31:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : ~v;
    n_checks++;
    if (e !== v) begin errors++; $display("Error rx_data expected %h seen %h", e, v); end
  endtask
  task automatic chk_tx(input logic [31:0] v);
    logic [31:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : ~v;
    n_checks++;
    if (e !== (v & m)) begin errors++; $display("Error port_data expected %h seen %h", e, v & m); end
  endtask
  // host word held until taken
  task automatic send(input logic [31:0] w);
    tx_data_i = w;
    tx_valid_i = 1'b1;
    @(posedge clk_i iff tx_ready_o);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // each word out against the oldest note
  always @(posedge clk_i) begin
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) chk_rx(rx_data_o);
    if (got === 1'b1) chk_tx(got_data);
  end

  initial begin
    logic [31:0] w [4];
    int s;
    logic st;
    {rst_n_i, rx_ready_i, tx_valid_i, tx_data_i, cfg_enable_i} = '0;
    {cfg_dir_out_i, cfg_last_port_i, cfg_ports_i, cfg_width_i} = '0;
    cfg_style_i = hpp_pkg::HPP_STYLE_REQACK;
    w[0] = $urandom(46);
    repeat (5) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    fork forever begin @(posedge clk_i); #1 rx_ready_i = 1'($urandom_range(1, 0)); end join_none
    foreach (CASES[i]) begin
      cfg_style_i = hpp_pkg::hpp_style_t'(CASES[i][8]);
      {cfg_dir_out_i, cfg_ports_i, cfg_last_port_i, cfg_width_i} = CASES[i][7:0];
      st = (cfg_style_i == hpp_pkg::HPP_STYLE_STROBE);
      s = st ? int'(cfg_last_port_i) : int'(cfg_ports_i[1:0] == 2'h0);
      m = lane_bytes();
      cfg_enable_i = 1'b1;
      for (int k = 0; k < 4; k++) begin w[k] = $urandom(); exp_q.push_back(w[k] & m); end
      if (cfg_dir_out_i) fork
        begin for (int k = 0; k < 4; k++) send(w[k]); tx_valid_i = 1'b0; end
        for (int k = 0; k < 4; k++) u_hpp_instr_model.take_word(st, s);
      join
      else for (int k = 0; k < 4; k++)
        if (st) u_hpp_instr_model.strobe_word(s, w[k]);
        else u_hpp_instr_model.req_word(s, w[k]);
      while (exp_q.size() != 0) @(posedge clk_i);
      #1 cfg_enable_i = 1'b0;
      repeat (10) @(posedge clk_i);
      #1 $display("test %0d done", i);
    end
    close_out();
  end

  // hang guard
  initial begin #160000; errors++; close_out(); end
endmodule // handshaked_parallel_port_test

bind hpp_port hpp_port_checker u_hpp_port_checker (.clk_i, .rst_n_i, .cfg_enable_i, .cfg_style_i,
  .cfg_dir_out_i, .cfg_ports_i, .cfg_last_port_i, .cfg_width_i, .rx_data_o, .rx_valid_o, .tx_ready_o,
  .port_data_oe_o, .req_i, .ack_o, .input_latch_strobe_n_i, .input_full_flag_o, .output_full_flag_n_o,
  .out_ack_n_i);
